/* File: swdt_apb_mst.sv */
// partner: apb master standing in for the processor core
`timescale 1ns/1ps
module swdt_apb_mst (
	input  wire logic        clk_i,		// bus clock
	input  wire logic [31:0] prdata_i,	// read data
	input  wire logic        pready_i,	// ready
	input  wire logic        pslverr_i,	// error
	output logic             psel_o,	// select
	output logic             penable_o,	// enable
	output logic             pwrite_o,	// direction
	output logic [31:0]      paddr_o,	// address
	output logic [31:0]      pwdata_o	// write data
);
	logic err;
	initial begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 32'h0;
		pwdata_o = 32'h0;
		err = 1'b0;
	end
	// request held until ready is sampled high
	task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r);
		@(posedge clk_i);
		psel_o <= 1'b1;
		pwrite_o <= w;
		paddr_o <= a;
		pwdata_o <= d;
		@(posedge clk_i);
		penable_o <= 1'b1;
		do @(posedge clk_i); while (pready_i !== 1'b1);
		r = prdata_i;
		err = pslverr_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
	endtask
endmodule // swdt_apb_mst

/* File: swdt_chk.sv */
// checker: port-level assertions for the system watchdog timer
`timescale 1ns/1ps
module swdt_chk
	import swdt_pkg::*;
(
	input wire logic        clk_sys_i,	// clock
	input wire logic        rst_i,		// external reset
	input wire logic        psel_i,		// select
	input wire logic        penable_i,	// enable
	input wire logic        pwrite_i,	// direction
	input wire logic [31:0] paddr_i,	// address
	input wire logic [31:0] pwdata_i,	// write data
	input wire logic [31:0] prdata_o,	// read data
	input wire logic        pready_o,	// ready
	input wire logic        pslverr_o,	// error
	input wire logic        irq_o,		// interrupt
	input wire logic        sys_reset_o	// chip reset
);
	logic acc, in_sp, fd_wr, bad;
	logic en_q, rs_q, aa_q, arm_q;
	assign acc   = psel_i && penable_i;
	assign in_sp = (paddr_i & SWDT_SPACE_MASK) == SWDT_MODE_ADDR;
	assign fd_wr = acc && pwrite_i && paddr_i == SWDT_FEED_ADDR;
	assign bad   = acc && in_sp && aa_q && !(fd_wr && pwdata_i[7:0] == SWDT_FEED_55);
	// shadows over-approximate the device state, so they stay safe after an underflow
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			{en_q, rs_q, aa_q, arm_q} <= '0;
		end else if (sys_reset_o) begin
			{en_q, rs_q, arm_q} <= '0;
		end else begin
			if (acc && pwrite_i && paddr_i == SWDT_MODE_ADDR) begin
				en_q <= en_q | pwdata_i[SWDT_EN_BIT];
				rs_q <= rs_q | pwdata_i[SWDT_RST_BIT];
			end
			if (acc && in_sp)
				aa_q <= fd_wr && pwdata_i[7:0] == SWDT_FEED_AA;
			if (fd_wr && aa_q && pwdata_i[7:0] == SWDT_FEED_55 && en_q)
				arm_q <= 1'b1;
		end
	end
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	chk_pulse_once: assert property (sys_reset_o |=> !sys_reset_o)
		else $error("chip reset request too long");
	chk_irq_needs_en: assert property (irq_o |-> en_q)
		else $error("irq without enable");
	chk_reset_needs_en: assert property (sys_reset_o |-> rs_q)
		else $error("chip reset without reset enable");
	chk_quiet_unarmed: assert property (!arm_q |-> !irq_o && !sys_reset_o)
		else $error("event before first feed");
	chk_feed_break: assert property (
		bad && en_q && rs_q && arm_q |-> ##[2:3] sys_reset_o)
		else $error("broken feed gave no reset");
	chk_irq_reset_clr: assert property (sys_reset_o |=> !irq_o)
		else $error("irq survived reset");
	chk_tc_floor: assert property (
		acc && !pwrite_i && paddr_i == SWDT_TC_ADDR |-> prdata_o >= SWDT_TC_MIN)
		else $error("constant below floor");
	chk_mode_set_only: assert property (
		acc && !pwrite_i && paddr_i == SWDT_MODE_ADDR |->
		(en_q || !prdata_o[SWDT_EN_BIT]) && (rs_q || !prdata_o[SWDT_RST_BIT]))
		else $error("mode bit set without write");
endmodule // swdt_chk
bind swdt_core swdt_chk u_chk (.clk_sys_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
	.pwdata_i, .prdata_o, .pready_o, .pslverr_o, .irq_o, .sys_reset_o);

/* File: swdt_core.sv */
// module: apb-facing top of the system watchdog timer
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module swdt_core
	import swdt_pkg::*;
(
	input  wire logic        clk_sys_i,	// system clock 200 MHz
	input  wire logic        rst_i,		// external reset, async, active high
	input  wire logic        psel_i,		// apb select
	input  wire logic        penable_i,	// apb enable
	input  wire logic        pwrite_i,	// apb direction
	input  wire logic [31:0] paddr_i,	// apb address
	input  wire logic [31:0] pwdata_i,	// apb write data
	output logic      [31:0] prdata_o,	// apb read data
	output logic             pready_o,	// apb ready
	output logic             pslverr_o,	// apb error
	output logic             irq_o,		// watchdog interrupt request
	output logic             sys_reset_o	// chip reset request, one-clock pulse
);
	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	swdt_evt_if evt ();

	wire       in_space  = (paddr_i & SWDT_SPACE_MASK) == SWDT_MODE_ADDR;
	wire       acc       = psel_i & penable_i & in_space;
	wire       wr        = acc & pwrite_i;
	wire       sel_mode  = paddr_i[3:0] == SWDT_MODE_ADDR[3:0];
	wire       sel_tc    = paddr_i[3:0] == SWDT_TC_ADDR[3:0];
	wire       sel_feed  = paddr_i[3:0] == SWDT_FEED_ADDR[3:0];
	wire       sel_value = paddr_i[3:0] == SWDT_VALUE_ADDR[3:0];
	wire       bad_addr  = ~in_space | (paddr_i[1:0] != 2'b00);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic        en_q, rst_en_q, tof_q, int_q, armed_q;
	logic [31:0] tc_q, tc_d;
	logic [31:0] cnt_q, cnt_d;
	logic [1:0]  pre_q;
	logic [31:0] rdata_d;
	logic        rst_pulse_q;

	// watchdog-caused reset: clears all but the time-out flag, the feed sequencer and the bus read registers
	wire soft_rst  = rst_pulse_q;
	wire running   = en_q & armed_q;
	wire tick      = running & (pre_q == SWDT_PRE_LAST);
	wire underflow = tick & (cnt_q == 32'h0000_0000);
	wire trig      = en_q & armed_q & (underflow | evt.feed_error);

	swdt_feed_seq u_feed (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.acc_i     (acc & ~bad_addr),
		.wr_i      (pwrite_i),
		.feed_i    (sel_feed),
		.data_i    (pwdata_i[7:0]),
		.evt       (evt.seq)
	);

	// ----------------------------------------------------------------
	// next values
	// ----------------------------------------------------------------
	// smaller constants clamp so the shortest timeout is 256 ticks
	assign tc_d = (pwdata_i < SWDT_TC_MIN) ? SWDT_TC_MIN : pwdata_i;

	always_comb begin
		cnt_d = cnt_q;
		if (evt.feed_done)
			cnt_d = tc_q;
		else if (tick)
			cnt_d = cnt_q - 32'h0000_0001;
	end

	always_comb begin
		rdata_d = 32'h0000_0000;
		if (sel_mode)
			rdata_d[SWDT_MODE_W-1:0] = {4'h0, int_q, tof_q, rst_en_q, en_q};
		else if (sel_tc)
			rdata_d = tc_q;
		else if (sel_value)
			rdata_d = cnt_q;
		// feed register reads as zero: no defined content
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			en_q     <= 1'b0;
			rst_en_q <= 1'b0;
		end else if (soft_rst | underflow) begin
			en_q     <= 1'b0;
			rst_en_q <= 1'b0;
		end else if (wr & sel_mode) begin
			// bits 7:4 ignored; software is expected to write zeros
			en_q     <= en_q | pwdata_i[SWDT_EN_BIT];
			rst_en_q <= rst_en_q | pwdata_i[SWDT_RST_BIT];
		end
	end

	// set wins over a clear in the same cycle
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			tof_q <= 1'b0;
		else if (trig)
			tof_q <= 1'b1;
		else if (wr & sel_mode & ~pwdata_i[SWDT_TOF_BIT])
			tof_q <= 1'b0;
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			int_q <= 1'b0;
		else if (trig)
			int_q <= 1'b1;
		else if (soft_rst)
			int_q <= 1'b0;
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			armed_q <= 1'b0;
		else if (soft_rst | underflow)
			armed_q <= 1'b0;
		else if (evt.feed_done & en_q)
			armed_q <= 1'b1;
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			tc_q <= SWDT_TC_RESET;
		else if (soft_rst)
			tc_q <= SWDT_TC_RESET;
		else if (wr & sel_tc)
			tc_q <= tc_d;
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q <= SWDT_TV_RESET;
			pre_q <= 2'b00;
		end else if (soft_rst) begin
			cnt_q <= SWDT_TV_RESET;
			pre_q <= 2'b00;
		end else begin
			cnt_q <= cnt_d;
			pre_q <= (running & ~evt.feed_done) ? pre_q + 2'b01 : 2'b00;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			rst_pulse_q <= 1'b0;
		else
			rst_pulse_q <= trig & rst_en_q;
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			prdata_o  <= 32'h0000_0000;
			pslverr_o <= 1'b0;
		end else if (psel_i & ~penable_i) begin
			prdata_o  <= rdata_d;
			pslverr_o <= bad_addr;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign pready_o    = 1'b1;
	assign sys_reset_o = rst_pulse_q;
	// the flag only sets while enabled, but enable drops at the underflow
	// itself, so gating by the live enable bit would hide the request
	assign irq_o       = int_q;
endmodule // swdt_core

/* File: swdt_evt_if.sv */
// interface: events passed from the feed sequencer to the watchdog core
`timescale 1ns/1ps
interface swdt_evt_if;
	logic feed_done;	// valid 0xaa,0x55 completed
	logic feed_error;	// sequence broken, delayed to second clock
	modport seq (output feed_done, output feed_error);
	modport core (input feed_done, input feed_error);
endinterface

/* File: swdt_feed_seq.sv */
// module: feed sequence tracker for the system watchdog timer
`timescale 1ns/1ps
module swdt_feed_seq
	import swdt_pkg::*;
(
	input  wire logic       clk_sys_i,	// system clock
	input  wire logic       rst_i,		// async reset, active high
	input  wire logic       acc_i,		// completed access in watchdog space
	input  wire logic       wr_i,		// access is a write
	input  wire logic       feed_i,		// access targets feed register
	input  wire logic [7:0] data_i,		// write data low byte
	swdt_evt_if.seq         evt			// events to core
);
	swdt_feed_state_type state_q, state_d;
	logic                err_q;

	wire is_aa = acc_i & wr_i & feed_i & (data_i == SWDT_FEED_AA);
	wire is_55 = acc_i & wr_i & feed_i & (data_i == SWDT_FEED_55);

	always_comb begin
		state_d = state_q;
		case (state_q)
			FEED_IDLE:  if (is_aa) state_d = FEED_AA;
			FEED_AA: begin
				if (is_55)
					state_d = FEED_IDLE;
				else if (acc_i)
					state_d = FEED_ERROR;
			end
			FEED_ERROR: state_d = FEED_IDLE;
			default:    state_d = FEED_IDLE;
		endcase
	end

	// error lands one clock after the error state: second clock after access
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= FEED_IDLE;
			err_q   <= 1'b0;
		end else begin
			state_q <= state_d;
			err_q   <= (state_q == FEED_ERROR);
		end
	end

	assign evt.feed_done  = (state_q == FEED_AA) & is_55;
	assign evt.feed_error = err_q;
endmodule // swdt_feed_seq

/* File: swdt_pkg.sv */
// package: register map, field layout and constants of the system watchdog timer
package swdt_pkg;
	// ----------------------------------------------------------------
	// register byte addresses (low bits decoded inside the block)
	// ----------------------------------------------------------------
	localparam logic [31:0] SWDT_MODE_ADDR  = 32'he000_0000;
	localparam logic [31:0] SWDT_TC_ADDR    = 32'he000_0004;
	localparam logic [31:0] SWDT_FEED_ADDR  = 32'he000_0008;
	localparam logic [31:0] SWDT_VALUE_ADDR = 32'he000_000c;
	localparam logic [31:0] SWDT_SPACE_MASK = 32'hffff_fff0;

	// ----------------------------------------------------------------
	// mode register fields
	// ----------------------------------------------------------------
	localparam int SWDT_EN_BIT   = 0;
	localparam int SWDT_RST_BIT  = 1;
	localparam int SWDT_TOF_BIT  = 2;
	localparam int SWDT_INT_BIT  = 3;
	localparam int SWDT_MODE_W   = 8;

	// ----------------------------------------------------------------
	// reset values and feed codes
	// ----------------------------------------------------------------
	localparam logic [31:0] SWDT_TC_RESET  = 32'h0000_00ff;
	localparam logic [31:0] SWDT_TC_MIN    = 32'h0000_00ff;
	localparam logic [31:0] SWDT_TV_RESET  = 32'h0000_00ff;
	localparam logic [7:0]  SWDT_FEED_AA   = 8'haa;
	localparam logic [7:0]  SWDT_FEED_55   = 8'h55;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int          SWDT_PRESCALE  = 4;
	localparam logic [1:0]  SWDT_PRE_LAST  = 2'(SWDT_PRESCALE - 1);

	typedef enum logic [1:0] {
		FEED_IDLE  = 2'b00,
		FEED_AA    = 2'b01,
		FEED_ERROR = 2'b10
	} swdt_feed_state_type;
endpackage

/* File: tb_system_watchdog_timer.sv */
// testbench: register-level tests of the system watchdog timer
`timescale 1ns/1ps
module tb_system_watchdog_timer;
	import swdt_pkg::*;
	logic        clk_sys_i, rst_i, psel, penable, pwrite, pready, pslverr, irq, srst;
	logic [31:0] paddr, pwdata, prdata, rd, v1;
	int          err_count, cmp_count, n;
	initial begin
		clk_sys_i = 1'b0;
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end
	swdt_core uut (.clk_sys_i, .rst_i, .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .irq_o(irq), .sys_reset_o(srst));
	swdt_apb_mst cpu (.clk_i(clk_sys_i), .prdata_i(prdata), .pready_i(pready),
		.pslverr_i(pslverr), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
		.paddr_o(paddr), .pwdata_o(pwdata));
	task automatic chk(input logic [31:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: got %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [31:0] a, d);
		cpu.xfer(1'b1, a, d, rd);
	endtask
	task automatic rdc(input logic [31:0] a, m, exp);
		cpu.xfer(1'b0, a, 32'h0, rd);
		chk(rd & m, exp);
	endtask
	task automatic feed();
		wr(SWDT_FEED_ADDR, 32'haa);
		wr(SWDT_FEED_ADDR, 32'h55);
	endtask
	// bounded wait; n counts the edges it took
	task automatic wait_ev(input bit rs, input int lim);
		n = 0;
		while ((rs ? srst : irq) !== 1'b1 && n < lim) begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end
	endtask
	task automatic give_verdict();
		$display("mismatches %0d, comparisons %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		#60us;
		err_count++;
		give_verdict();
	end
	initial begin
		err_count = 0;
		cmp_count = 0;
		rst_i = 1'b1;
		repeat (16) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		rdc(SWDT_MODE_ADDR, 32'hf, 32'h0);
		rdc(SWDT_TC_ADDR, '1, SWDT_TC_RESET);
		feed();
		repeat (40) @(posedge clk_sys_i);
		rdc(SWDT_VALUE_ADDR, '1, SWDT_TV_RESET);
		wr(SWDT_TC_ADDR, 32'h10);
		rdc(SWDT_TC_ADDR, '1, SWDT_TC_MIN);
		wr(32'he000_0010, 32'h0);
		chk(32'(cpu.err), 32'h1);
		wr(SWDT_VALUE_ADDR, 32'h1234);
		rdc(SWDT_VALUE_ADDR, '1, SWDT_TV_RESET);
		wr(SWDT_MODE_ADDR, 32'h1);
		wr(SWDT_MODE_ADDR, 32'h0);
		rdc(SWDT_MODE_ADDR, 32'h3, 32'h1);
		wr(SWDT_FEED_ADDR, 32'haa);
		rdc(SWDT_MODE_ADDR, 32'h1, 32'h1);
		wait_ev(1'b0, 8);
		chk(32'(irq), 32'h0);
		wr(SWDT_TC_ADDR, 32'h400);
		rdc(SWDT_TC_ADDR, '1, 32'h400);
		feed();
		// value captured two edges after the reload, before the first tick
		cpu.xfer(1'b0, SWDT_VALUE_ADDR, 32'h0, v1);
		chk(v1, 32'h400);
		// ten ticks of four clocks land before the next capture
		repeat (37) @(posedge clk_sys_i);
		rdc(SWDT_VALUE_ADDR, '1, 32'h3f6);
		wr(SWDT_TC_ADDR, 32'hff);
		feed();
		wait_ev(1'b0, 1100);
		chk(n, 32'd1024);
		rdc(SWDT_MODE_ADDR, 32'hf, 32'hc);
		wr(SWDT_MODE_ADDR, 32'h0);
		rdc(SWDT_MODE_ADDR, 32'hc, 32'h8);
		chk(32'(irq), 32'h1);
		wr(SWDT_TC_ADDR, 32'h100);
		wr(SWDT_MODE_ADDR, 32'h3);
		feed();
		wait_ev(1'b1, 1100);
		chk(32'(srst), 32'h1);
		rdc(SWDT_MODE_ADDR, 32'hf, 32'h4);
		chk(32'(irq), 32'h0);
		rdc(SWDT_TC_ADDR, '1, SWDT_TC_RESET);
		wr(SWDT_MODE_ADDR, 32'h3);
		feed();
		wr(SWDT_FEED_ADDR, 32'haa);
		cpu.xfer(1'b0, SWDT_VALUE_ADDR, 32'h0, rd);
		wait_ev(1'b1, 6);
		chk(n, 32'h2);
		// let the pending reset check finish, then an external reset clears the flag
		repeat (2) @(posedge clk_sys_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		rdc(SWDT_MODE_ADDR, 32'hf, 32'h0);
		give_verdict();
	end
endmodule // tb_system_watchdog_timer
